// ### src/pwm_consts.svh
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH

// ----------------------------------------
// Control and status byte fields
// ----------------------------------------
`define CTRL_REG_BIT 7
`define CTRL_WR_BIT 6
`define ADDR_PERIOD 2'h2
`define ADDR_FREQ 2'h3

// ----------------------------------------
// Duty word fields
// ----------------------------------------
`define DUTY_MSB 14
`define DUTY_LSB 5
`define DUTY_FULL 10'h3ff

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PERIOD_RST_STD 16'h0fa0
`define PERIOD_RST_LOW 16'h04e2
`define FREQ_RST_STD 16'h00fa
`define FREQ_RST_LOW 16'h0064

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define STD_DIGIT_NS 1000
`define LOW_DIGIT_NS 8000
`define STD_DIGITS_PER_S 20'd1000000
`define LOW_DIGITS_PER_S 20'd125000

`endif

// ### src/pwm_pkg.sv
package pwm_pkg;

    // Process image byte and word
    typedef logic [7:0] byte_t;
    typedef logic [15:0] word_t;
    // Duty value after dropping low bits
    typedef logic [9:0] duty_t;

    // Parameter access sequencer
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_DIV
    } acc_state_t;

endpackage

// ### src/pwm_divider.sv
`timescale 1ns/10ps
module pwm_divider (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Request
    input wire logic start,
    input wire logic [19:0] dividend,
    input wire pwm_pkg::word_t divisor,
    // Result
    output logic done,
    output pwm_pkg::word_t quot
);
    import pwm_pkg::*;

    // ----------------------------------------
    // Restoring divider, one bit per cycle
    // ----------------------------------------
    logic busy_q, busy_d;        // Division running
    logic [4:0] step_q, step_d;  // Bits left
    logic [16:0] rem_q, rem_d;   // Partial remainder
    logic [19:0] q_q, q_d;       // Quotient shift register
    logic done_q, done_d;        // Finish pulse
    word_t quot_q, quot_d;       // Saturated result
    logic [16:0] trial;          // Shifted remainder

    // Next state of the divider
    always_comb begin
        busy_d = busy_q;
        step_d = step_q;
        rem_d = rem_q;
        q_d = q_q;
        done_d = 1'b0;
        quot_d = quot_q;
        trial = {rem_q[15:0], q_q[19]};
        if (start) begin
            // Load dividend, clear remainder
            busy_d = 1'b1;
            step_d = 5'h14;
            rem_d = 17'h0;
            q_d = dividend;
        end else if (busy_q) begin
            // Subtract when it fits
            if (trial >= {1'b0, divisor}) begin
                rem_d = trial - {1'b0, divisor};
                q_d = {q_q[18:0], 1'b1};
            end else begin
                rem_d = trial;
                q_d = {q_q[18:0], 1'b0};
            end
            step_d = step_q - 5'h1;
            if (step_q == 5'h1) begin
                // Too large or divide by zero saturates
                busy_d = 1'b0;
                done_d = 1'b1;
                quot_d = (q_d[19:16] != 4'h0) ? 16'hffff : q_d[15:0];
            end
        end
    end

    // Divider registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_q <= 1'b0;
            step_q <= 5'h0;
            rem_q <= 17'h0;
            q_q <= 20'h0;
            done_q <= 1'b0;
            quot_q <= 16'h0;
        end else begin
            busy_q <= busy_d;
            step_q <= step_d;
            rem_q <= rem_d;
            q_q <= q_d;
            done_q <= done_d;
            quot_q <= quot_d;
        end
    end

    assign done = done_q;
    assign quot = quot_q;

endmodule

// ### src/two_channel_pwm.sv
`timescale 1ns/10ps
`include "pwm_consts.svh"
module two_channel_pwm #(
    parameter bit LOW_FREQ = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Channel 0 image from coupler
    input wire pwm_pkg::byte_t ctrl0,
    input wire pwm_pkg::word_t data0,
    // Channel 1 image from coupler
    input wire pwm_pkg::byte_t ctrl1,
    input wire pwm_pkg::word_t data1,
    // Channel 0 image to coupler
    output pwm_pkg::byte_t status0,
    output pwm_pkg::word_t in_data0,
    // Channel 1 image to coupler
    output pwm_pkg::byte_t status1,
    output pwm_pkg::word_t in_data1,
    // Pulse outputs
    output logic [1:0] pwm_out
);
    import pwm_pkg::*;

    // ----------------------------------------
    // Variant constants
    // ----------------------------------------
    // Reset values per variant
    localparam word_t PERIOD_RST = LOW_FREQ ? `PERIOD_RST_LOW : `PERIOD_RST_STD;
    localparam word_t FREQ_RST = LOW_FREQ ? `FREQ_RST_LOW : `FREQ_RST_STD;
    // Length of one period digit
    localparam int DIGIT_NS = LOW_FREQ ? `LOW_DIGIT_NS : `STD_DIGIT_NS;
    localparam int DIGIT_CYC = DIGIT_NS / `CLK_PERIOD_NS;
    localparam logic [9:0] PRE_MAX = 10'(DIGIT_CYC - 1);
    // Digits in one second
    localparam logic [19:0] DIGITS_PER_S =
        LOW_FREQ ? `LOW_DIGITS_PER_S : `STD_DIGITS_PER_S;

    // ----------------------------------------
    // Channel arrays
    // ----------------------------------------
    byte_t ctrl [2];         // Control bytes
    word_t data [2];         // Output data words
    byte_t stat_q [2];       // Status bytes
    byte_t stat_d [2];
    word_t rd_q [2];         // Input data words
    word_t rd_d [2];
    duty_t duty_q [2];       // Latched duty
    duty_t duty_d [2];
    logic [1:0] req;         // Pending access
    logic [1:0] cmp;         // Access finished now
    logic [1:0] pwm_q, pwm_d;

    assign ctrl[0] = ctrl0;
    assign ctrl[1] = ctrl1;
    assign data[0] = data0;
    assign data[1] = data1;

    // ----------------------------------------
    // Parameter registers and access sequencer
    // ----------------------------------------
    acc_state_t st_q, st_d;  // Sequencer state
    logic ch_q, ch_d;        // Channel waiting on divider
    word_t period_q, period_d;
    word_t freq_q, freq_d;
    word_t cmp_data;         // Read value on completion
    logic gnt;               // Channel served this cycle
    logic div_start;
    logic div_done;
    word_t div_quot;

    // Period from frequency
    pwm_divider u_div (
        .clk(clk),
        .resetn(resetn),
        .start(div_start),
        .dividend(DIGITS_PER_S),
        .divisor(freq_q),
        .done(div_done),
        .quot(div_quot)
    );

    // Next state of the sequencer
    always_comb begin
        st_d = st_q;
        ch_d = ch_q;
        period_d = period_q;
        freq_d = freq_q;
        div_start = 1'b0;
        cmp = 2'b00;
        cmp_data = 16'h0;
        // Channel 0 wins a tie
        gnt = req[0] ? 1'b0 : 1'b1;
        case (st_q)
            ST_IDLE: begin
                if (|req) begin
                    if (!ctrl[gnt][`CTRL_WR_BIT]) begin
                        // Read returns value at once
                        cmp[gnt] = 1'b1;
                        case (ctrl[gnt][1:0])
                            `ADDR_PERIOD: cmp_data = period_q;
                            `ADDR_FREQ: cmp_data = freq_q;
                            default: cmp_data = 16'h0;
                        endcase
                    end else if (ctrl[gnt][1:0] == `ADDR_PERIOD) begin
                        // Direct period write
                        period_d = data[gnt];
                        cmp[gnt] = 1'b1;
                    end else if (ctrl[gnt][1:0] == `ADDR_FREQ) begin
                        // Frequency write starts division
                        freq_d = data[gnt];
                        div_start = 1'b1;
                        ch_d = gnt;
                        st_d = ST_DIV;
                    end else begin
                        // Unused address, acknowledged only
                        cmp[gnt] = 1'b1;
                    end
                end
            end
            ST_DIV: begin
                if (div_done) begin
                    // Store computed period
                    period_d = div_quot;
                    cmp[ch_q] = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers, defaults at power-on
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            ch_q <= 1'b0;
            period_q <= PERIOD_RST;
            freq_q <= FREQ_RST;
        end else begin
            st_q <= st_d;
            ch_q <= ch_d;
            period_q <= period_d;
            freq_q <= freq_d;
        end
    end

    // ----------------------------------------
    // Shared period counter
    // ----------------------------------------
    logic [9:0] pre_q, pre_d;  // Cycles within a digit
    word_t cnt_q, cnt_d;       // Digits within a period
    logic tick;                // One digit elapsed

    // Next prescaler and counter values
    always_comb begin
        tick = (pre_q == PRE_MAX);
        pre_d = tick ? 10'h0 : pre_q + 10'h1;
        cnt_d = cnt_q;
        if (tick) begin
            // Wrap at period, both channels alike
            if (({1'b0, cnt_q} + 17'h1) >= {1'b0, period_q}) begin
                cnt_d = 16'h0;
            end else begin
                cnt_d = cnt_q + 16'h1;
            end
        end
        // A new period restarts the count so it never sits past the end
        if (period_d != period_q) begin
            cnt_d = 16'h0;
        end
    end

    // Counter registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre_q <= 10'h0;
            cnt_q <= 16'h0;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------
    // Per channel image and pulse logic
    // ----------------------------------------
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            logic [25:0] phase;  // Counter scaled by full step
            logic [25:0] limit;  // Period scaled by duty

            // Pending when bit 7 set and not yet answered
            assign req[c] = ctrl[c][`CTRL_REG_BIT] & ~stat_q[c][7];

            // Next image and pulse values
            always_comb begin
                stat_d[c] = stat_q[c];
                rd_d[c] = rd_q[c];
                duty_d[c] = duty_q[c];
                if (!ctrl[c][`CTRL_REG_BIT]) begin
                    // Process data exchange
                    stat_d[c] = 8'h0;
                    rd_d[c] = 16'h0;
                    duty_d[c] = data[c][`DUTY_MSB:`DUTY_LSB];
                end else if (cmp[c]) begin
                    // Echo bit 7 and address
                    stat_d[c] = {1'b1, 5'h0, ctrl[c][1:0]};
                    rd_d[c] = ctrl[c][`CTRL_WR_BIT] ? 16'h0 : cmp_data;
                end
                phase = 26'(cnt_q) * 26'(`DUTY_FULL);
                limit = 26'(period_q) * 26'(duty_q[c]);
                pwm_d[c] = (phase < limit);
            end

            // Channel registers
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    stat_q[c] <= 8'h0;
                    rd_q[c] <= 16'h0;
                    duty_q[c] <= 10'h0;
                    pwm_q[c] <= 1'b0;
                end else begin
                    stat_q[c] <= stat_d[c];
                    rd_q[c] <= rd_d[c];
                    duty_q[c] <= duty_d[c];
                    pwm_q[c] <= pwm_d[c];
                end
            end
        end
    endgenerate

    // Outputs from flip-flops
    assign status0 = stat_q[0];
    assign status1 = stat_q[1];
    assign in_data0 = rd_q[0];
    assign in_data1 = rd_q[1];
    assign pwm_out = pwm_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Duty taken from bits 14 to 5 only
    property p_duty_bits;
        @(posedge clk) disable iff (!resetn)
        !ctrl0[7] |=> duty_q[0] == $past(data0[14:5]);
    endproperty
    a_duty_bits: assert property (p_duty_bits) else $error("duty bits wrong");

    // Full duty holds output high
    property p_full_on;
        @(posedge clk) disable iff (!resetn)
        (duty_q[0] == 10'h3ff && period_q != 16'h0) [*2] |-> pwm_out[0];
    endproperty
    a_full_on: assert property (p_full_on) else $error("full duty not high");

    // Zero duty holds output low
    property p_zero_off;
        @(posedge clk) disable iff (!resetn)
        (duty_q[1] == 10'h0) [*2] |-> !pwm_out[1];
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("zero duty not low");

    // Divider result lands in period register
    property p_freq_period;
        @(posedge clk) disable iff (!resetn)
        div_done && st_q == ST_DIV |=> period_q == $past(div_quot);
    endproperty
    a_freq_period: assert property (p_freq_period) else $error("period not updated");

    // Counter advances only on a digit tick
    property p_tick;
        @(posedge clk) disable iff (!resetn)
        (cnt_q != $past(cnt_q)) && cnt_q != 16'h0 |-> $past(tick);
    endproperty
    a_tick: assert property (p_tick) else $error("counter off tick");

    // Period write from channel 0
    property p_period_wr;
        @(posedge clk) disable iff (!resetn)
        ctrl0 == 8'hc2 && !status0[7] && st_q == ST_IDLE
            |=> period_q == $past(data0) && status0 == 8'h82 ##1 in_data0 == 16'h0;
    endproperty
    a_period_wr: assert property (p_period_wr) else $error("period write failed");

    // Read of period returns register
    property p_period_rd;
        @(posedge clk) disable iff (!resetn)
        ctrl0 == 8'h82 && !status0[7] && st_q == ST_IDLE
            |=> status0 == 8'h82 && in_data0 == $past(period_q);
    endproperty
    a_period_rd: assert property (p_period_rd) else $error("period read wrong");

    // Answer echoes address with bit 6 clear
    property p_echo;
        @(posedge clk) disable iff (!resetn)
        $rose(status1[7]) |-> status1[6:2] == 5'h0 && status1[1:0] == $past(ctrl1[1:0]);
    endproperty
    a_echo: assert property (p_echo) else $error("status echo wrong");

    // Bit 7 low restores process exchange
    property p_back;
        @(posedge clk) disable iff (!resetn)
        !ctrl1[7] |=> status1 == 8'h0 && in_data1 == 16'h0;
    endproperty
    a_back: assert property (p_back) else $error("no return to process data");

endmodule

// ### tb/coupler_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Coupler side of the process image
// ----------------------------------------
module coupler_model (
    // Clock
    input wire logic clk,
    // Image towards the block
    output pwm_pkg::byte_t ctrl0,
    output pwm_pkg::word_t data0,
    output pwm_pkg::byte_t ctrl1,
    output pwm_pkg::word_t data1,
    // Image from the block
    input wire pwm_pkg::byte_t status0,
    input wire pwm_pkg::byte_t status1,
    input wire pwm_pkg::word_t in_data0,
    input wire pwm_pkg::word_t in_data1
);
    import pwm_pkg::*;
    word_t duty_word [2]; // Duty words put back after an access

    // Process mode with zero duty from time zero
    initial begin
        duty_word = '{16'h0000, 16'h0000};
        ctrl0 = 8'h00;
        ctrl1 = 8'h00;
        data0 = 16'h0000;
        data1 = 16'h0000;
    end

    // Drive one channel's control byte and data bytes together
    task automatic drive(input int ch, input byte_t c, input word_t d);
        if (ch == 0) begin
            ctrl0 = c;
            data0 = d;
        end else begin
            ctrl1 = c;
            data1 = d;
        end
    endtask

    // New duty word, sign bit kept clear
    task automatic set_duty(input int ch, input word_t w);
        @(negedge clk);
        duty_word[ch] = w & 16'h7fff;
        drive(ch, 8'h00, duty_word[ch]);
    endtask

    // One register access; held until the status byte acknowledges
    task automatic access(input int ch, input bit wr, input logic [1:0] a, input word_t v,
                          output byte_t st, output word_t rd, output int lat);
        @(negedge clk);
        drive(ch, {1'b1, wr, 4'h0, a}, v);
        lat = 0;
        do begin
            @(negedge clk);
            lat++;
        end while ((ch == 0 ? status0[7] : status1[7]) !== 1'b1 && lat < 64);
        st = (ch == 0) ? status0 : status1;
        rd = (ch == 0) ? in_data0 : in_data1;
        // Back to process exchange with the duty word restored
        drive(ch, 8'h00, duty_word[ch]);
    endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps
// ----------------------------------------
// Top-level bench
// ----------------------------------------
module tb_top;
    import pwm_pkg::*;
    logic clk; // 100 MHz clock
    logic resetn; // Active-low reset
    byte_t ctrl0, ctrl1, status0, status1;
    word_t data0, data1, in_data0, in_data1;
    logic [1:0] pwm_out; // Pulse outputs
    byte_t status_l0, status_l1; // Low variant status bytes
    word_t in_data_l0, in_data_l1; // Low variant input words
    logic [1:0] pwm_low; // Low variant pulse outputs
    int per_l; // Low variant model period register
    int frq_l; // Low variant model frequency register
    int error_cnt = 0; // Mismatches
    int cmp_count = 0; // Comparisons
    int cycles = 0; // Hang guard
    int per_m; // Model period register
    int frq_m; // Model frequency register
    int frq_tab [5] = '{250, 950, 20000, 10, 0}; // Frequencies incl. saturation
    word_t duty_tab [8]; // Duty word pairs
    word_t rnd;

    two_channel_pwm #(.LOW_FREQ(1'b0)) dut (
        .clk(clk), .resetn(resetn), .ctrl0(ctrl0), .data0(data0), .ctrl1(ctrl1),
        .data1(data1), .status0(status0), .in_data0(in_data0), .status1(status1),
        .in_data1(in_data1), .pwm_out(pwm_out)
    );

    // Low-frequency variant fed the same image
    two_channel_pwm #(.LOW_FREQ(1'b1)) dut_low (
        .clk(clk), .resetn(resetn), .ctrl0(ctrl0), .data0(data0), .ctrl1(ctrl1),
        .data1(data1), .status0(status_l0), .in_data0(in_data_l0), .status1(status_l1),
        .in_data1(in_data_l1), .pwm_out(pwm_low)
    );

    coupler_model cpl (
        .clk(clk), .ctrl0(ctrl0), .data0(data0), .ctrl1(ctrl1), .data1(data1),
        .status0(status0), .status1(status1), .in_data0(in_data0), .in_data1(in_data1)
    );

    // Clock generation
    always #5 clk = ~clk;

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            conclude();
        end
    end

    // ----------------------------------------
    // Register access against the model
    // ----------------------------------------
    task automatic reg_acc(input int ch, input bit wr, input logic [1:0] a, input word_t v);
        byte_t st;
        word_t rd;
        int lat;
        word_t exp;
        word_t exp_l;
        exp = (wr || a < 2'h2) ? 16'h0000 : (a == 2'h2 ? per_m[15:0] : frq_m[15:0]);
        exp_l = (wr || a < 2'h2) ? 16'h0000 : (a == 2'h2 ? per_l[15:0] : frq_l[15:0]);
        cpl.access(ch, wr, a, v, st, rd, lat);
        check({8'h00, st}, {8'h00, 1'b1, 5'h00, a});
        check(rd, exp);
        check(ch == 0 ? {8'h00, status_l0} : {8'h00, status_l1}, {8'h00, 1'b1, 5'h00, a});
        check(ch == 0 ? in_data_l0 : in_data_l1, exp_l);
        if (wr && a == 2'h3) begin
            check(16'(lat), 16'h0016);
        end else begin
            check(16'(lat), 16'h0001);
        end
        // Model update, frequency write recomputes the period
        if (wr && a == 2'h2) begin
            per_m = v;
            per_l = v;
        end else if (wr && a == 2'h3) begin
            frq_m = v;
            per_m = (v == 0 || 1000000 / v > 65535) ? 65535 : 1000000 / v;
            frq_l = v;
            per_l = (v == 0 || 125000 / v > 65535) ? 65535 : 125000 / v;
        end
        repeat (2) @(negedge clk);
        check(ch == 0 ? {8'h00, status0} : {8'h00, status1}, 16'h0000);
        check(ch == 0 ? in_data0 : in_data1, 16'h0000);
        check(ch == 0 ? {8'h00, status_l0} : {8'h00, status_l1}, 16'h0000);
        check(ch == 0 ? in_data_l0 : in_data_l1, 16'h0000);
    endtask

    // High cycles per period from the duty word
    function automatic int exp_hi(input word_t w);
        int n = 0;
        for (int c = 0; c < per_m; c++) begin
            if (c * 1023 < per_m * int'(w[14:5])) begin
                n++;
            end
        end
        return n * 100;
    endfunction

    // Measure both outputs over one full period after settling
    task automatic pwm_meas(input word_t w0, input word_t w1);
        int hi [2];
        int hl [2];
        cpl.set_duty(0, w0);
        cpl.set_duty(1, w1);
        repeat (2 * per_m * 100) @(negedge clk);
        hi = '{0, 0};
        hl = '{0, 0};
        repeat (per_m * 100) begin
            @(negedge clk);
            hi[0] += int'(pwm_out[0] === 1'b1);
            hi[1] += int'(pwm_out[1] === 1'b1);
            hl[0] += int'(pwm_low[0] === 1'b1);
            hl[1] += int'(pwm_low[1] === 1'b1);
        end
        // Low variant: only full and zero duty are independent of its slower digit
        if (w0[14:5] == 10'h3ff || w0[14:5] == 10'h000) begin
            check(16'(hl[0]), w0[14:5] == 10'h000 ? 16'h0000 : 16'(per_m * 100));
        end
        if (w1[14:5] == 10'h3ff || w1[14:5] == 10'h000) begin
            check(16'(hl[1]), w1[14:5] == 10'h000 ? 16'h0000 : 16'(per_m * 100));
        end
        check(16'(hi[0]), 16'(exp_hi(w0 & 16'h7fff)));
        check(16'(hi[1]), 16'(exp_hi(w1 & 16'h7fff)));
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        rnd = 16'($urandom(32'hbc1ea1f8));
        per_m = 4000;
        frq_m = 250;
        per_l = 1250;
        frq_l = 100;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        // Every address read once, defaults included
        for (int a = 0; a < 4; a++) begin
            reg_acc(a % 2, 1'b0, 2'(a), 16'($urandom));
        end
        // Unused address write is acknowledged and leaves nothing
        reg_acc(0, 1'b1, 2'h0, 16'($urandom));
        reg_acc(1, 1'b0, 2'h0, 16'h0000);
        // Period written on one channel, read on the other
        reg_acc(0, 1'b1, 2'h2, 16'($urandom_range(1, 65535)));
        reg_acc(1, 1'b0, 2'h2, 16'h0000);
        // Frequency writes recompute the period
        foreach (frq_tab[i]) begin
            reg_acc(i % 2, 1'b1, 2'h3, 16'(frq_tab[i]));
            reg_acc((i + 1) % 2, 1'b0, 2'h2, 16'h0000);
            reg_acc(i % 2, 1'b0, 2'h3, 16'h0000);
        end
        // Short period for the pulse checks
        reg_acc(1, 1'b1, 2'h2, 16'h0014);
        duty_tab = '{16'h7fff, 16'h001f, 16'h3fff, 16'h0020,
                     16'h1fff, 16'h0100, rnd, 16'($urandom)};
        for (int i = 0; i < 8; i += 2) begin
            pwm_meas(duty_tab[i], duty_tab[i + 1]);
        end
        conclude();
    end
endmodule
